// ### logic/nvm_crc8_checker.v
`timescale 1ns/1ps
`include "nvm_crc_consts.vh"
module nvm_crc8_checker (
  input  wire       MCLK,
  input  wire       RST_N,
  input  wire       LOAD_REQ,
  output wire       LOAD_BUSY,
  output reg        LOAD_DONE,
  output reg        NVM_OK,
  output reg  [7:0] NVM_CRC,
  input  wire [7:0] NVM_DATA,
  output reg  [4:0] NVM_ADDR,
  input  wire       RDMEM_REQ,
  input  wire [4:0] RDMEM_ADDR,
  output reg        RDMEM_VALID,
  output reg  [7:0] RDMEM_DATA,
  input  wire       STR_START,
  input  wire       STR_VALID,
  output wire       STR_READY,
  input  wire [7:0] STR_DATA,
  output reg  [7:0] STR_CRC,
  output reg        STR_CRC_VALID
);
  reg  [7:0]  shadow [0:`NVM_BYTES-1];
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [4:0]  addr_q;
  reg         fetch_q;
  reg         busy_q;
  reg         src_q;
  reg  [7:0]  dat_q;
  reg  [7:0]  rem_q;
  reg  [3:0]  bit_q;
  reg         last_q;
  wire        f_valid;
  wire [7:0]  f_data;
  wire        f_ready;
  wire        take_nvm;
  wire        take_str;
  wire [7:0]  rem_sh;
  wire        flip;

  // Stream waits in the FIFO while the engine is busy or a load runs
  byte_fifo #(
    .WIDTH (`CRC_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .MCLK      (MCLK),
    .RST_N     (RST_N),
    .IN_VALID  (STR_VALID),
    .IN_READY  (STR_READY),
    .IN_DATA   (STR_DATA),
    .OUT_VALID (f_valid),
    .OUT_READY (f_ready),
    .OUT_DATA  (f_data)
  );

  assign LOAD_BUSY = (state_q == `ST_LOAD);
  assign take_nvm  = fetch_q & ~busy_q;
  assign take_str  = (state_q != `ST_LOAD) & f_valid & ~busy_q;
  assign f_ready   = take_str;
  assign flip      = dat_q[7] ^ rem_q[7];
  assign rem_sh    = {rem_q[6:0], 1'b0} ^ (flip ? `CRC_POLY : 8'h00);

  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE: begin
        if (LOAD_REQ) begin
          state_d = `ST_LOAD;
        end
      end
      `ST_LOAD: begin
        if (busy_q && last_q && src_q == `SRC_NVM &&
            bit_q == `CRC_BITS_LAST) begin
          state_d = `ST_DONE;
        end
      end
      `ST_DONE: begin
        if (LOAD_REQ) begin
          state_d = `ST_LOAD;
        end
      end
      default: begin
        state_d = `ST_IDLE;
      end
    endcase
  end

  always @(posedge MCLK) begin
    if (take_nvm) begin
      shadow[addr_q] <= NVM_DATA;
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q       <= `ST_IDLE;
      addr_q        <= 5'h00;
      NVM_ADDR      <= 5'h00;
      fetch_q       <= 1'b0;
      busy_q        <= 1'b0;
      src_q         <= `SRC_STREAM;
      dat_q         <= 8'h00;
      rem_q         <= `CRC_INIT;
      bit_q         <= 4'h0;
      last_q        <= 1'b0;
      LOAD_DONE     <= 1'b0;
      NVM_OK        <= 1'b0;
      NVM_CRC       <= `CRC_INIT;
      STR_CRC       <= `CRC_INIT;
      STR_CRC_VALID <= 1'b0;
      RDMEM_VALID   <= 1'b0;
      RDMEM_DATA    <= 8'h00;
    end else begin
      state_q       <= state_d;
      LOAD_DONE     <= 1'b0;
      STR_CRC_VALID <= 1'b0;
      RDMEM_VALID   <= 1'b0;
      if (RDMEM_REQ && state_q == `ST_DONE) begin
        RDMEM_VALID <= 1'b1;
        RDMEM_DATA  <= shadow[RDMEM_ADDR];
      end
      if (state_q != `ST_LOAD && state_d == `ST_LOAD) begin
        addr_q   <= 5'h00;
        NVM_ADDR <= 5'h00;
        fetch_q  <= 1'b0;
        NVM_OK   <= 1'b0;
      end else if (state_q == `ST_LOAD && !busy_q && !fetch_q &&
                   !(last_q && src_q == `SRC_NVM)) begin
        fetch_q  <= 1'b1; // Address settles one cycle before sampling
      end
      if (take_nvm) begin
        fetch_q <= 1'b0;
        busy_q  <= 1'b1;
        src_q   <= `SRC_NVM;
        dat_q   <= NVM_DATA;
        if (addr_q == 5'h00) begin
          rem_q <= `CRC_INIT;
        end
        bit_q   <= 4'h0;
        last_q  <= (addr_q == `NVM_LAST);
        if (addr_q != `NVM_LAST) begin
          addr_q   <= addr_q + 5'h01;
          NVM_ADDR <= addr_q + 5'h01;
        end
      end else if (take_str) begin
        busy_q <= 1'b1;
        src_q  <= `SRC_STREAM;
        dat_q  <= f_data;
        bit_q  <= 4'h0;
        last_q <= 1'b0;
        if (STR_START) begin
          rem_q <= `CRC_INIT;
        end else begin
          rem_q <= STR_CRC;
        end
      end else if (busy_q) begin
        dat_q <= {dat_q[6:0], 1'b0};
        rem_q <= rem_sh;
        bit_q <= bit_q + 4'h1;
        if (bit_q == `CRC_BITS_LAST) begin
          busy_q <= 1'b0;
          if (src_q == `SRC_STREAM) begin
            STR_CRC       <= rem_sh;
            STR_CRC_VALID <= 1'b1;
          end else if (last_q) begin
            NVM_CRC   <= rem_sh;
            NVM_OK    <= (rem_sh == 8'h00);
            LOAD_DONE <= 1'b1;
            last_q    <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ### logic/nvm_crc_consts.vh
`ifndef NVM_CRC_CONSTS_VH
`define NVM_CRC_CONSTS_VH
`define CRC_WIDTH      8
`define CRC_POLY       8'h31
`define CRC_INIT       8'h00
`define CRC_BITS       4'h8
`define CRC_BITS_LAST  4'h7
`define NVM_BITS       256
`define NVM_BYTES      32
`define NVM_AW         5
`define NVM_LAST       5'h1f
`define FIFO_DEPTH     8
`define ST_IDLE        2'h0
`define ST_LOAD        2'h1
`define ST_DONE        2'h2
`define SRC_STREAM     1'b0
`define SRC_NVM        1'b1
`endif

// ### logic/byte_fifo.v
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             MCLK,
  input  wire             RST_N,
  input  wire             IN_VALID,
  output wire             IN_READY,
  input  wire [WIDTH-1:0] IN_DATA,
  output wire             OUT_VALID,
  input  wire             OUT_READY,
  output wire [WIDTH-1:0] OUT_DATA
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign IN_READY  = (cnt_q != DEPTH[AW:0]);
  assign OUT_VALID = (cnt_q != {(AW+1){1'b0}});
  assign OUT_DATA  = mem[rd_q];
  assign push      = IN_VALID & IN_READY;
  assign pop       = OUT_VALID & OUT_READY;

  always @(posedge MCLK) begin
    if (push) begin
      mem[wr_q] <= IN_DATA;
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### bench/crc8_sva_assertions.sv
`timescale 1ns/1ps
module crc8_sva (
  input wire       MCLK,
  input wire       RST_N,
  input wire       LOAD_REQ,
  input wire       LOAD_BUSY,
  input wire       LOAD_DONE,
  input wire       NVM_OK,
  input wire [7:0] NVM_CRC,
  input wire       RDMEM_REQ,
  input wire       RDMEM_VALID,
  input wire [7:0] RDMEM_DATA,
  input wire [7:0] STR_CRC,
  input wire       STR_CRC_VALID
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_load_start:
    assert property (LOAD_REQ && !LOAD_BUSY |=> LOAD_BUSY[*8])
    else $error("load not started");
  chk_done_idle: assert property (LOAD_DONE |-> !LOAD_BUSY)
    else $error("done while busy");
  chk_done_pulse: assert property (LOAD_DONE |=> !LOAD_DONE)
    else $error("done too long");
  chk_ok_match:
    assert property (LOAD_DONE |-> NVM_OK == (NVM_CRC == 8'h00))
    else $error("ok flag wrong");
  chk_byte_time:
    assert property (STR_CRC_VALID |=> !STR_CRC_VALID[*8])
    else $error("byte too fast");
  chk_crc_hold:
    assert property (!STR_CRC_VALID |-> $stable(STR_CRC))
    else $error("crc moved");
  chk_rd_answer:
    assert property (RDMEM_VALID |-> $past(RDMEM_REQ))
    else $error("read unasked");
  chk_rd_hold:
    assert property (!RDMEM_VALID |-> $stable(RDMEM_DATA))
    else $error("read data moved");
  cover property (LOAD_DONE);
  cover property (STR_CRC_VALID && STR_CRC == 8'h13);
  cover property (RDMEM_VALID);
endmodule

// ### bench/nvm_image_model.sv
`timescale 1ns/1ps
module nvm_image_model #(
  parameter [255:0] IMG = 256'h0
) (
  input  wire [4:0] addr,
  input  wire       bad,
  output wire [7:0] data
);
  // Same-cycle read; bad flips bit 0 of all bytes
  assign data = IMG[255 - 8 * addr -: 8] ^ {7'h00, bad};
endmodule

// ### bench/nvm_crc8_checker_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h", $time, a); end end
module nvm_crc8_checker_tb;
  localparam [255:0] IMG = {128'h00cf03000000000145133d081c1a3c91,
                            128'h968a4ead63d74ebc61c3302600000139};
  reg         mclk = 1'b0, rst_n = 1'b0, ld = 1'b0, rq = 1'b0, a = 1'b0;
  reg         st = 1'b1, sv = 1'b0, bad = 1'b0;
  reg  [4:0]  ra = 5'h00;
  reg  [7:0]  sd = 8'h00, e, q [0:7];
  reg  [15:0] lf = 16'h17b3;
  integer     failures = 0, comparisons = 0, cyc = 0, i, n;
  wire        busy, done, ok, rv, rdy, cv;
  wire [7:0]  nc, nd, rd, sc;
  wire [4:0]  na;
  nvm_crc8_checker dut (.MCLK(mclk), .RST_N(rst_n), .LOAD_REQ(ld),
    .LOAD_BUSY(busy), .LOAD_DONE(done), .NVM_OK(ok), .NVM_CRC(nc),
    .NVM_DATA(nd), .NVM_ADDR(na), .RDMEM_REQ(rq), .RDMEM_ADDR(ra),
    .RDMEM_VALID(rv), .RDMEM_DATA(rd), .STR_START(st), .STR_VALID(sv),
    .STR_READY(rdy), .STR_DATA(sd), .STR_CRC(sc), .STR_CRC_VALID(cv));
  nvm_image_model #(.IMG(IMG)) mem (.addr(na), .bad(bad), .data(nd));
  always #10 mclk = ~mclk;
  function [7:0] crc(input [7:0] c, input [7:0] d);
    integer k;
    begin
      crc = c;
      for (k = 0; k < 8; k = k + 1)
        crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[7 - k]) ? 8'h31 : 8'h00);
    end
  endfunction
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task push(input [7:0] b);
    begin
      @(posedge mclk);
      sv <= 1'b1;
      sd <= b;
      @(negedge mclk);
      while (rdy !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      sv <= 1'b0;
    end
  endtask
  task wsv;
    integer k;
    begin
      @(negedge mclk);
      for (k = 0; k < 60 && cv !== 1'b1; k = k + 1) @(negedge mclk);
      `CHK(cv, 1'b1)
    end
  endtask
  task lgo;
    begin
      @(posedge mclk);
      ld <= 1'b1;
      @(posedge mclk);
      ld <= 1'b0;
    end
  endtask
  task lchk;
    integer k;
    begin
      @(negedge mclk);
      `CHK(busy, 1'b1)
      for (k = 0; k < 900 && done !== 1'b1; k = k + 1) @(negedge mclk);
      `CHK(done, 1'b1)
      @(negedge mclk);
      `CHK(busy, 1'b0)
      e = 8'h00;
      for (k = 0; k < 32; k = k + 1)
        e = crc(e, IMG[255 - 8 * k -: 8] ^ {7'h00, bad});
      `CHK(nc, e)
      `CHK(ok, e === 8'h00)
      $display("load test done");
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    lgo;
    lchk;
    for (i = 0; i < 6; i = i + 1) begin
      lf = nx(lf);
      n = (i == 5) ? 31 : lf[4:0];
      @(posedge mclk);
      rq <= 1'b1;
      ra <= n[4:0];
      @(posedge mclk);
      rq <= 1'b0;
      @(negedge mclk);
      `CHK({rv, rd}, {1'b1, IMG[255 - 8 * n -: 8]})
    end
    $display("read test done");
    push(8'hbe);
    wsv;
    `CHK(sc, crc(8'h00, 8'hbe))
    @(posedge mclk);
    st <= 1'b0;
    push(8'hef);
    wsv;
    `CHK(sc, 8'h13)
    e = 8'h13;
    for (i = 0; i < 6; i = i + 1) begin
      lf = nx(lf);
      e = crc(e, lf[7:0]);
      push(lf[7:0]);
      wsv;
      `CHK(sc, e)
    end
    $display("stream test done");
    @(posedge mclk);
    st <= 1'b1;
    bad <= 1'b1;
    lgo;
    n = 0;
    sv <= 1'b1;
    sd <= lf[7:0];
    repeat (12) begin
      @(negedge mclk);
      a = rdy;
      @(posedge mclk);
      if (a === 1'b1) begin
        q[n[2:0]] = sd;
        n = n + 1;
        lf = nx(lf);
        sd <= lf[7:0];
      end
    end
    sv <= 1'b0;
    `CHK(n, 8)
    lchk;
    for (i = 0; i < 8; i = i + 1) begin
      wsv;
      `CHK(sc, crc(8'h00, q[i]))
    end
    $display("fill test done");
    end_of_test;
  end
endmodule
bind nvm_crc8_checker crc8_sva chk (.MCLK(MCLK), .RST_N(RST_N),
  .LOAD_REQ(LOAD_REQ), .LOAD_BUSY(LOAD_BUSY), .LOAD_DONE(LOAD_DONE),
  .NVM_OK(NVM_OK), .NVM_CRC(NVM_CRC), .RDMEM_REQ(RDMEM_REQ),
  .RDMEM_VALID(RDMEM_VALID), .RDMEM_DATA(RDMEM_DATA), .STR_CRC(STR_CRC),
  .STR_CRC_VALID(STR_CRC_VALID));
